//--- design/adc_sequencing_control.v
// Purpose: sequencing and register file of a 10-bit successive-
//          approximation converter, reached over Avalon-MM
// Assumes: i_clk is the oscillator; all inputs but i_rst synchronous to it;
//          i_rc_tick is a one-cycle pulse per dedicated RC period
// Notes:   comparator and trial DAC are outside; this block steers them
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.vh"

module adc_sequencing_control #(
   parameter TEMP_C = 50        // die temperature for acquisition estimate
) (
   input  wire        i_clk,          // oscillator clock
   input  wire        i_rst,          // async reset, active high
   input  wire [9:0]  i_address,      // byte address
   input  wire        i_read,         // avalon read
   input  wire        i_write,        // avalon write
   input  wire [31:0] i_writedata,    // avalon write data
   output reg  [31:0] o_readdata,     // avalon read data
   output reg         o_waitrequest,  // avalon wait
   input  wire        i_sleep,        // core is asleep
   input  wire        i_rc_tick,      // dedicated rc clock pulse
   input  wire        i_cmp_high,     // input at or above trial code
   output reg  [9:0]  o_trial_code,   // trial code to dac
   output reg         o_sample,       // sampling switch closed
   output reg         o_converter_on, // analog core powered
   output reg  [2:0]  o_channel,      // selected input channel
   output reg         o_ref_select,   // 1: external reference pin
   output reg  [7:0]  o_analog_pins,  // pins in analog mode
   output reg         o_irq,          // level interrupt
   output reg         o_wake          // wake request to core
);

   // ******************************
   // timing constants
   // ******************************
   localparam ACQ_NS = `T_AMP_NS + `T_HOLD_CHARGE_NS
                     + (TEMP_C - `T_REF_TEMP_C) * `T_COEF_NS_PER_C;
   localparam ACQ_CYCLES = (ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [11:0] ACQ_LAST = ACQ_CYCLES[11:0];

   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_DELAY = 2'd1;
   localparam [1:0] ST_CONV  = 2'd2;
   localparam [1:0] ST_ABORT = 2'd3;

   // ******************************
   // registers
   // ******************************
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  clksel_reg;
   reg  [7:0]  pins_reg;
   reg  [7:0]  status_reg;
   reg  [7:0]  mask_reg;
   reg  [7:0]  res_high_reg;
   reg  [7:0]  res_low_reg;
   reg         run_reg;
   reg         pd_reg;
   reg  [1:0]  state_reg;
   reg  [5:0]  pre_reg;
   reg  [3:0]  tad_reg;
   reg  [9:0]  sar_reg;
   reg  [9:0]  bit_reg;
   reg  [11:0] acq_reg;
   reg  [5:0]  div_last;
   reg  [7:0]  rd_mux;
   reg  [9:0]  final_code;
   reg         load_result;
   reg  [7:0]  irq_next;

   wire        access;
   wire        wr_hit;
   wire [7:0]  idx;
   wire        use_rc;
   wire        tad_tick;
   wire        start_req;
   wire        stop_req;
   wire        sleep_kill;
   wire        sleep_done;
   wire        done_evt;
   wire        acq_ready;

   assign idx    = i_address[9:2];
   assign access = (i_read | i_write) & ~o_waitrequest;
   assign wr_hit = access & i_write;

   // ******************************
   // clock select decode
   // ******************************
   // x11 picks rc; others divide the oscillator
   assign use_rc = (clksel_reg[`BIT_CLK_LO+1:`BIT_CLK_LO] == 2'b11);

   always @* begin
      case (clksel_reg[`BIT_CLK_HI:`BIT_CLK_LO])
         3'b000:  div_last = 6'd1;  // osc/2
         3'b100:  div_last = 6'd3;  // osc/4
         3'b001:  div_last = 6'd7;  // osc/8
         3'b101:  div_last = 6'd15; // osc/16
         3'b010:  div_last = 6'd31; // osc/32
         3'b110:  div_last = 6'd63; // osc/64
         default: div_last = 6'd1;  // rc: prescaler unused
      endcase
   end

   // one conversion period per tick
   assign tad_tick = use_rc ? i_rc_tick : (pre_reg == div_last);

   // ******************************
   // sequencing requests
   // ******************************
   // a start while busy or powered down is simply dropped
   assign start_req  = wr_hit & (idx == `IDX_MAIN_CONTROL)
                     & i_writedata[`BIT_RUN] & ~run_reg
                     & ctrl_reg[`BIT_POWER_ON] & ~pd_reg;
   // software clearing run while busy aborts
   assign stop_req   = wr_hit & (idx == `IDX_MAIN_CONTROL)
                     & ~i_writedata[`BIT_RUN] & run_reg;
   // other clocks cannot run in sleep
   assign sleep_kill = i_sleep & ~use_rc;
   assign done_evt   = (state_reg == ST_CONV) & tad_tick
                     & (tad_reg == `TAD_LAST);
   assign sleep_done = done_evt & i_sleep;
   assign acq_ready  = (acq_reg == ACQ_LAST);

   // ******************************
   // result formatting
   // ******************************
   always @* begin
      final_code  = i_cmp_high ? (sar_reg | bit_reg) : sar_reg;
      load_result = done_evt & ~sleep_kill;
   end

   // ******************************
   // conversion state machine
   // ******************************
   // reset stops the converter and drops any conversion
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         run_reg   <= 1'b0;
         pre_reg   <= 6'd0;
         tad_reg   <= 4'd0;
         sar_reg   <= 10'h000;
         bit_reg   <= 10'h000;
      end else begin
         // prescaler counts between ticks and is held at zero while idle
         if (tad_tick || state_reg == ST_IDLE)
            pre_reg <= 6'd0;
         else
            pre_reg <= pre_reg + 6'd1;
         case (state_reg)
            ST_IDLE: begin
               tad_reg <= 4'd0;
               if (start_req && !sleep_kill) begin
                  run_reg   <= 1'b1;
                  // rc start waits one instruction for sleep
                  state_reg <= use_rc ? ST_DELAY : ST_CONV;
               end
            end
            ST_DELAY: begin
               // reuses the prescaler as instruction counter
               if (stop_req || sleep_kill) begin
                  run_reg   <= 1'b0;
                  state_reg <= ST_IDLE;
               end else if (pre_reg == `INSTR_CYCLE_CLKS - 6'd1) begin
                  state_reg <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (sleep_kill) begin
                  // abort and power down in sleep
                  run_reg   <= 1'b0;
                  state_reg <= ST_IDLE;
               end else if (stop_req) begin
                  // results untouched unless the last period ends in this same cycle; settle before reacquire
                  run_reg   <= 1'b0;
                  tad_reg   <= 4'd0;
                  state_reg <= ST_ABORT;
               end else if (tad_tick) begin
                  // 1 sampling period then 10 bit decisions
                  if (tad_reg == 4'd0) begin
                     sar_reg <= 10'h000;
                     bit_reg <= `CODE_MSB_TRIAL;
                  end else begin
                     sar_reg <= final_code;
                     bit_reg <= {1'b0, bit_reg[9:1]};
                  end
                  if (tad_reg == `TAD_LAST) begin
                     run_reg   <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
                  tad_reg <= tad_reg + 4'd1;
               end
            end
            ST_ABORT: begin
               // two periods, then sampling resumes by itself
               if (tad_tick)
                  tad_reg <= tad_reg + 4'd1;
               if (tad_reg == `TAD_ABORT_WAIT)
                  state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
               run_reg   <= 1'b0;
            end
         endcase
      end
   end

   // ******************************
   // power-down while asleep
   // ******************************
   // analog core off whenever asleep on the oscillator clock, or on an rc completion in sleep with done masked; the power bit itself keeps its value
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         pd_reg <= 1'b0;
      else if (!i_sleep)
         pd_reg <= 1'b0;
      else if (sleep_kill)
         pd_reg <= 1'b1;
      else if (sleep_done && !mask_reg[`BIT_DONE])
         pd_reg <= 1'b1;
   end

   // ******************************
   // acquisition timer
   // ******************************
   // restarts on channel change; software polls ready before run
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         acq_reg <= 12'd0;
      else if (wr_hit && idx == `IDX_MAIN_CONTROL
               && i_writedata[`BIT_CHAN_HI:`BIT_CHAN_LO]
                  != ctrl_reg[`BIT_CHAN_HI:`BIT_CHAN_LO])
         acq_reg <= 12'd0;
      else if (state_reg == ST_IDLE && !acq_ready)
         acq_reg <= acq_reg + 12'd1;
   end

   // ******************************
   // result registers
   // ******************************
   // no reset on purpose: contents survive a device reset
   always @(posedge i_clk) begin
      if (load_result) begin
         if (ctrl_reg[`BIT_JUSTIFY]) begin
            res_high_reg <= {6'h00, final_code[9:8]};
            res_low_reg  <= final_code[7:0];
         end else begin
            res_high_reg <= final_code[9:2];
            res_low_reg  <= {final_code[1:0], 6'h00};
         end
      end
   end

   // ******************************
   // control registers
   // ******************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg   <= `RST_MAIN_CONTROL;
         clksel_reg <= `RST_CLOCK_SELECT;
         pins_reg   <= `RST_ANALOG_PINS;
         mask_reg   <= `RST_IRQ;
      end else if (wr_hit) begin
         case (idx)
            `IDX_MAIN_CONTROL: ctrl_reg   <= i_writedata[7:0]
                                             & `MASK_MAIN_CONTROL;
            `IDX_CLOCK_SELECT: clksel_reg <= i_writedata[7:0]
                                             & `MASK_CLOCK_SELECT;
            `IDX_ANALOG_PINS:  pins_reg   <= i_writedata[7:0];
            `IDX_IRQ_MASK:     mask_reg   <= i_writedata[7:0];
            default:           ctrl_reg   <= ctrl_reg;
         endcase
      end
   end

   // ******************************
   // interrupt status
   // ******************************
   // write one clears; a same-cycle completion still sets
   always @* begin
      irq_next = status_reg;
      if (wr_hit && idx == `IDX_IRQ_STATUS)
         irq_next = status_reg & ~i_writedata[7:0];
      if (load_result)
         irq_next[`BIT_DONE] = 1'b1;
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         status_reg <= `RST_IRQ;
         o_irq      <= 1'b0;
         o_wake     <= 1'b0;
      end else begin
         status_reg <= irq_next;
         o_irq      <= |(irq_next & mask_reg);
         o_wake     <= i_sleep & |(irq_next & mask_reg);
      end
   end

   // ******************************
   // read mux
   // ******************************
   always @* begin
      case (idx)
         `IDX_RESULT_HIGH:  rd_mux = res_high_reg;
         `IDX_MAIN_CONTROL: rd_mux = {ctrl_reg[7:2], run_reg, ctrl_reg[0]};
         `IDX_ANALOG_PINS:  rd_mux = pins_reg;
         `IDX_RESULT_LOW:   rd_mux = res_low_reg;
         `IDX_CLOCK_SELECT: rd_mux = clksel_reg;
         `IDX_IRQ_STATUS:   rd_mux = {acq_ready, status_reg[6:0]};
         `IDX_IRQ_MASK:     rd_mux = mask_reg;
         default:           rd_mux = 8'h00;
      endcase
   end

   // ******************************
   // avalon slave handshake
   // ******************************
   // one wait state per access keeps the read path registered
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_waitrequest <= 1'b1;
         o_readdata    <= 32'h0000_0000;
      end else begin
         if ((i_read || i_write) && o_waitrequest) begin
            o_waitrequest <= 1'b0;
            o_readdata    <= {24'h000000, rd_mux};
         end else begin
            o_waitrequest <= 1'b1;
         end
      end
   end

   // ******************************
   // analog front-end drive
   // ******************************
   // sampling switch stays closed while powered and idle and through the rc start
   // delay, since conversion has not begun yet; the hold capacitor has
   // no discharge path, so the old charge stays until next sample
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sample       <= 1'b0;
         o_converter_on <= 1'b0;
         o_trial_code   <= 10'h000;
         o_channel      <= 3'd0;
         o_ref_select   <= 1'b0;
         o_analog_pins  <= `RST_ANALOG_PINS;
      end else begin
         o_converter_on <= ctrl_reg[`BIT_POWER_ON] & ~pd_reg;
         o_sample       <= ctrl_reg[`BIT_POWER_ON] & ~pd_reg
                           & (state_reg == ST_IDLE
                              || state_reg == ST_DELAY);
         o_trial_code   <= sar_reg | bit_reg;
         o_channel      <= ctrl_reg[`BIT_CHAN_HI:`BIT_CHAN_LO];
         o_ref_select   <= ctrl_reg[`BIT_REF_SEL];
         o_analog_pins  <= pins_reg;
      end
   end

endmodule
`default_nettype wire

//--- design/adc_seq_defines.vh
// Purpose: constants for the converter sequencing block
// Assumes: included by its bare name from design files
// Notes:   register indices; byte address is four times the index
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// ******************************
// register indices
// ******************************
`define IDX_RESULT_HIGH   8'h1e
`define IDX_MAIN_CONTROL  8'h1f
`define IDX_ANALOG_PINS   8'h91
`define IDX_RESULT_LOW    8'h9e
`define IDX_CLOCK_SELECT  8'h9f
`define IDX_IRQ_STATUS    8'ha0
`define IDX_IRQ_MASK      8'ha1

// ******************************
// reset values
// ******************************
`define RST_MAIN_CONTROL  8'h00
`define RST_ANALOG_PINS   8'hff
`define RST_CLOCK_SELECT  8'h00
`define RST_IRQ           8'h00

// ******************************
// field positions
// ******************************
`define BIT_JUSTIFY       7
`define BIT_REF_SEL       6
`define BIT_CHAN_HI       4
`define BIT_CHAN_LO       2
`define BIT_RUN           1
`define BIT_POWER_ON      0
`define BIT_CLK_HI        6
`define BIT_CLK_LO        4
`define BIT_DONE          0
`define BIT_ACQ_READY     7
`define MASK_MAIN_CONTROL 8'hdf
`define MASK_CLOCK_SELECT 8'h70

// ******************************
// conversion timing
// ******************************
`define TAD_PER_CONV      4'd11
`define TAD_LAST          4'd10
`define TAD_ABORT_WAIT    4'd2
`define INSTR_CYCLE_CLKS  6'd4
`define CODE_MSB_TRIAL    10'h200
`define CLK_PERIOD_NS     10
`define T_AMP_NS          2000
`define T_HOLD_CHARGE_NS  16470
`define T_COEF_NS_PER_C   50
`define T_REF_TEMP_C      25

`endif

//--- testbench/adc_seq_chk.sv
// Purpose: port assertions for the converter sequencer
// Assumes: bound to adc_sequencing_control
// Notes:   clock select is shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk (
   input wire        i_clk,          // oscillator clock
   input wire        i_rst,          // async reset
   input wire [9:0]  i_address,      // byte address
   input wire        i_read,         // read strobe
   input wire        i_write,        // write strobe
   input wire [31:0] i_writedata,    // write data
   input wire [31:0] o_readdata,     // read data
   input wire        o_waitrequest,  // bus wait
   input wire        i_sleep,        // core asleep
   input wire        o_sample,       // sampling switch
   input wire        o_converter_on, // analog power
   input wire [7:0]  o_analog_pins,  // analog pins
   input wire        o_irq,          // interrupt
   input wire        o_wake          // wake request
);
   // ******************************
   // helper logic
   // ******************************
   reg  [2:0] sel_reg;
   reg  [9:0] low_reg;
   wire [7:0] idx    = i_address[9:2];
   wire       rc     = sel_reg[1:0] == 2'b11;
   wire [9:0] lim    = 10'd13 * (10'd2 << {sel_reg[1], sel_reg[0], sel_reg[2]}) + 10'd4;
   wire       mapped = idx inside {8'h1e, 8'h1f, 8'h91, 8'h9e, 8'h9f, 8'ha0, 8'ha1};
   wire       start  = i_write && !o_waitrequest && idx == 8'h1f && i_writedata[1:0] == 2'b11
                       && o_converter_on && o_sample;
   // counter saturates so a stuck converter cannot wrap past the limit
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_reg <= 3'h0;
         low_reg <= 10'h0;
      end else begin
         if (i_write && !o_waitrequest && idx == 8'h9f)
            sel_reg <= i_writedata[6:4];
         if (o_sample || !o_converter_on)
            low_reg <= 10'h0;
         else if (low_reg != 10'h3ff)
            low_reg <= low_reg + 10'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ******************************
   // assertions
   // ******************************
   reset_outputs_a: assert property (disable iff (1'b0) i_rst |-> !o_converter_on
      && !o_irq && !o_wake && o_analog_pins == 8'hff && o_waitrequest)
      else $error("outputs not at reset state");
   wake_sleep_a: assert property (o_wake |-> o_irq && $past(i_sleep))
      else $error("wake without interrupt in sleep");
   rc_delay_a: assert property (start && rc |=> o_sample [*3])
      else $error("rc conversion started without delay");
   conv_start_a: assert property (start && !rc && !i_sleep |-> ##[1:3] !o_sample)
      else $error("start request did not begin conversion");
   conv_length_a: assert property (!rc |-> low_reg <= lim)
      else $error("conversion longer than its clock count");
   sleep_abort_a: assert property (i_sleep && !rc && o_converter_on && !o_sample
      |-> ##[1:2] !o_converter_on) else $error("sleep did not stop converter");
   bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("access not answered next cycle");
   wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low for more than a cycle");
   read_data_a: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0
      && (mapped || o_readdata[7:0] == 8'h0)) else $error("bad read data");
endmodule
`default_nettype wire

//--- testbench/analog_source_model.sv
// Purpose: analog source and comparator seen by the sequencer
// Assumes: source holds i_level steady during a conversion
// Notes:   unpowered comparator answers with a toggling level
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
   input  wire logic       i_clk,          // oscillator clock
   input  wire logic [9:0] i_level,        // code the source stands at
   input  wire logic [9:0] i_trial_code,   // trial code from block
   input  wire logic       i_converter_on, // comparator powered
   output logic            o_cmp_high      // input at or above trial
);
   logic toggle_reg = 1'b0;
   // toggling so a powered-down read never looks like a stable answer
   always @(posedge i_clk) toggle_reg <= !toggle_reg;
   assign o_cmp_high = i_converter_on ? (i_level >= i_trial_code) : toggle_reg;
endmodule
`default_nettype wire

//--- testbench/adc_sequencing_control_test.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: avalon accesses of two cycles, rc tick every 40 clocks
// Notes:   results checked only where justify is unchanged since load
`timescale 1ns/1ps
`default_nettype none
bind adc_sequencing_control adc_seq_chk i_adc_seq_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_sleep(i_sleep),
   .o_sample(o_sample), .o_converter_on(o_converter_on), .o_analog_pins(o_analog_pins),
   .o_irq(o_irq), .o_wake(o_wake));
module adc_sequencing_control_test;
   logic        i_clk = 1'b0, i_rst = 1'b0, i_read = 1'b0, i_write = 1'b0;
   logic        i_sleep = 1'b0, i_rc_tick = 1'b0;
   logic [9:0]  i_address = 10'h0, level = 10'h0;
   logic [31:0] i_writedata = 32'h0;
   logic [7:0]  ctl;
   int          mismatches = 0, total_checks = 0;
   logic [7:0]  ri [6] = '{8'h1f, 8'h91, 8'h9f, 8'ha0, 8'ha1, 8'h40};
   logic [7:0]  rv [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [9:0]  lv [6] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a, 10'h001, 10'h200};
   logic [2:0]  cs [6] = '{3'd0, 3'd4, 3'd1, 3'd5, 3'd2, 3'd6};
   wire  [31:0] o_readdata;
   wire  [9:0]  o_trial_code;
   wire  [7:0]  o_analog_pins;
   wire  [2:0]  o_channel;
   wire         o_waitrequest, i_cmp_high, o_sample, o_converter_on, o_ref_select, o_irq, o_wake;
   adc_sequencing_control i_adc_sequencing_control (.i_clk(i_clk), .i_rst(i_rst),
      .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_sleep(i_sleep),
      .i_rc_tick(i_rc_tick), .i_cmp_high(i_cmp_high), .o_trial_code(o_trial_code),
      .o_sample(o_sample), .o_converter_on(o_converter_on), .o_channel(o_channel),
      .o_ref_select(o_ref_select), .o_analog_pins(o_analog_pins), .o_irq(o_irq), .o_wake(o_wake));
   analog_source_model i_analog_source_model (.i_clk(i_clk), .i_level(level),
      .i_trial_code(o_trial_code), .i_converter_on(o_converter_on), .o_cmp_high(i_cmp_high));
   // ******************************
   // clocks and tasks
   // ******************************
   always #5 i_clk = !i_clk;
   // rc oscillator runs free, unrelated to any request
   always begin
      repeat (39) @(posedge i_clk);
      i_rc_tick <= 1'b1;
      @(posedge i_clk);
      i_rc_tick <= 1'b0;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic checkr(input int got, input int lo, input int hi);
      total_checks++;
      if (!(got >= lo && got <= hi)) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge i_clk);
      i_address   <= {idx, 2'b00};
      i_write     <= w;
      i_read      <= !w;
      i_writedata <= {24'h0, wd};
      @(posedge i_clk);
      while (o_waitrequest !== 1'b0) @(posedge i_clk);
      rd = o_readdata[7:0];
      i_write <= 1'b0;
      i_read  <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] t;
      bus(1'b1, idx, d, t);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
      logic [7:0] t;
      bus(1'b0, idx, 8'h00, t);
      check8(t & m, exp);
   endtask
   task automatic res(input logic [9:0] c, input logic j);
      rd(8'h1e, j ? {6'h0, c[9:8]} : c[9:2], 8'hff);
      rd(8'h9e, j ? c[7:0] : {c[1:0], 6'h0}, 8'hff);
   endtask
   task automatic conv(input logic [7:0] c, input int div);
      int n;
      n = 0;
      wr(8'h1f, c | 8'h02);
      while (o_sample !== 1'b0) begin @(posedge i_clk); n++; end
      while (o_sample !== 1'b1) begin @(posedge i_clk); n++; end
      checkr(n, 10 * div, 11 * div + 6);
   endtask
   task automatic wait_run();
      logic [7:0] t;
      t = 8'h02;
      while (t[1] !== 1'b0) bus(1'b0, 8'h1f, 8'h00, t);
   endtask
   // ******************************
   // tests
   // ******************************
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      // a real rising edge on reset, so the async branches fire at time zero
      i_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int k = 0; k < 6; k++) rd(ri[k], rv[k], 8'hff);
      check8(o_analog_pins, 8'hff);
      wr(8'h91, 8'h5a);
      rd(8'h91, 8'h5a, 8'hff);
      check8(o_analog_pins, 8'h5a);
      wr(8'ha1, 8'h01);
      wr(8'h1f, 8'h4d);
      rd(8'ha0, 8'h00, 8'h80);
      check8({4'h0, o_ref_select, o_channel}, 8'h0b);
      repeat (2000) @(posedge i_clk);
      rd(8'ha0, 8'h80, 8'h80);
      // every oscillator divide, alternating justification
      for (int k = 0; k < 6; k++) begin
         ctl = {k[0], 7'h4d};
         level <= lv[k];
         wr(8'h9f, {1'b0, cs[k], 4'h0});
         conv(ctl, 2 << k);
         rd(8'h1f, ctl, 8'hff);
         rd(8'ha0, 8'h01, 8'h01);
         check8({7'h0, o_irq}, 8'h01);
         res(lv[k], k[0]);
         wr(8'ha0, 8'h01);
         rd(8'ha0, 8'h00, 8'h01);
         check8({7'h0, o_irq}, 8'h00);
      end
      // abort mid conversion at the slowest divide
      wr(8'h9f, 8'h60);
      wr(8'h1f, 8'hcf);
      rd(8'h1f, 8'hcf, 8'hff);
      wr(8'h1f, 8'hcd);
      repeat (40) @(posedge i_clk);
      check8({7'h0, o_sample}, 8'h00);
      repeat (180) @(posedge i_clk);
      check8({7'h0, o_sample}, 8'h01);
      res(lv[5], 1'b1);
      rd(8'ha0, 8'h00, 8'h01);
      // rc clock through sleep, interrupt disabled then enabled
      wr(8'h9f, 8'h30);
      wr(8'ha1, 8'h00);
      level <= 10'h123;
      wr(8'h1f, 8'h4f);
      i_sleep <= 1'b1;
      wait_run();
      rd(8'h1f, 8'h4d, 8'hff);
      check8({6'h0, o_converter_on, o_wake}, 8'h00);
      res(10'h123, 1'b0);
      i_sleep <= 1'b0;
      wr(8'ha0, 8'h01);
      wr(8'ha1, 8'h01);
      level <= 10'h2cd;
      wr(8'h1f, 8'h4f);
      i_sleep <= 1'b1;
      wait_run();
      check8({7'h0, o_wake}, 8'h01);
      res(10'h2cd, 1'b0);
      i_sleep <= 1'b0;
      wr(8'ha0, 8'h01);
      // sleep with oscillator clock aborts
      wr(8'h9f, 8'h60);
      wr(8'h1f, 8'h4f);
      i_sleep <= 1'b1;
      rd(8'h1f, 8'h4d, 8'hff);
      check8({7'h0, o_converter_on}, 8'h00);
      res(10'h2cd, 1'b0);
      i_sleep <= 1'b0;
      // reset in mid conversion
      repeat (4) @(posedge i_clk);
      wr(8'h1f, 8'h4f);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(8'h1f, 8'h00, 8'hff);
      check8({7'h0, o_converter_on}, 8'h00);
      res(10'h2cd, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
